// ### design/pccb_consts.vh
`ifndef PCCB_CONSTS_VH
`define PCCB_CONSTS_VH
`define PCCB_OFS_PCIX_STATUS 8'hE4
`define PCCB_OFS_BRIDGE_CTRL 8'h84
`define PCCB_OFS_TRANS_CMD 8'h04
`define PCCB_DEVNUM_LSB 3
`define PCCB_DEVNUM_MSB 7
`define PCCB_BUSNUM_LSB 8
`define PCCB_BUSNUM_MSB 15
`define PCCB_DEVNUM_RESET 5'h1F
`define PCCB_DEVNUM_PCI 5'h00
`define PCCB_BUSNUM_RESET 8'hFF
`define PCCB_BIT_IBRESET 5
`define PCCB_BIT_OBUSY 15
`define PCCB_BIT_IBUSY 14
`define PCCB_BIT_BME 2
`define PCCB_BIT_MSE 1
`define PCCB_RESET_CLOCKS 6'h28
`define PCCB_RESET_CNT_W 6
`endif

// ### design/pccb_sync.v
`timescale 1ns/1ps
module pccb_sync (
    input wire clk_in,
    input wire arst_n_in,
    input wire d_in,
    output wire q_out
);
    reg s1_reg;
    reg s2_reg;
    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= d_in;
            s2_reg <= s1_reg;
        end
    end
    assign q_out = s2_reg;
endmodule

// ### design/pccb_top.v
`timescale 1ns/1ps
`include "pccb_consts.vh"
module pccb_top (
    input wire clk_in,
    input wire arst_n_in,
    input wire pci_clk_in,
    input wire pcix_mode_in,
    input wire cfg_wr_in,
    input wire cfg_rd_in,
    input wire attr_phase_in,
    input wire [7:0] cfg_addr_in,
    input wire [31:0] ad_in,
    input wire [15:0] cfg_wdata_in,
    input wire ib_wr_in,
    input wire [7:0] ib_addr_in,
    input wire [15:0] ib_wdata_in,
    input wire ob_busy_in,
    input wire ib_busy_in,
    input wire sec_cfg_req_in,
    input wire [4:0] sec_dev_in,
    input wire [7:0] sec_reg_in,
    output reg [15:0] cfg_rdata_out,
    output reg [15:0] ib_rdata_out,
    output reg [15:0] pcix_status_out,
    output reg ibus_reset_out,
    output reg sec_cfg_valid_out,
    output reg [31:0] sec_cfg_addr_out,
    output reg pri_cfg_fwd_out
);
    wire pclk_s;
    wire obusy_s;
    wire ibusy_s;
    wire mode_s;
    pccb_sync u_sync_clk (.clk_in(clk_in), .arst_n_in(arst_n_in), .d_in(pci_clk_in),
        .q_out(pclk_s));
    pccb_sync u_sync_ob (.clk_in(clk_in), .arst_n_in(arst_n_in), .d_in(ob_busy_in),
        .q_out(obusy_s));
    pccb_sync u_sync_ib (.clk_in(clk_in), .arst_n_in(arst_n_in), .d_in(ib_busy_in),
        .q_out(ibusy_s));
    pccb_sync u_sync_md (.clk_in(clk_in), .arst_n_in(arst_n_in), .d_in(pcix_mode_in),
        .q_out(mode_s));
    reg pclk_d_reg;
    reg [4:0] devnum_reg;
    reg [7:0] busnum_reg;
    reg ibreset_reg;
    reg [2:1] cmd_reg;
    reg [5:0] rst_cnt_reg;
    wire pclk_rise = pclk_s & ~pclk_d_reg;
    wire soft_rst = (rst_cnt_reg != 6'h00);
    wire cfg_wr_set = cfg_wr_in && cfg_addr_in == `PCCB_OFS_BRIDGE_CTRL &&
        cfg_wdata_in[`PCCB_BIT_IBRESET];
    wire ib_wr_set = ib_wr_in && ib_addr_in == `PCCB_OFS_BRIDGE_CTRL &&
        ib_wdata_in[`PCCB_BIT_IBRESET];
    function [15:0] rd_mux;
        input [7:0] a;
        begin
            rd_mux = 16'h0000;
            case (a)
                `PCCB_OFS_PCIX_STATUS: rd_mux = {busnum_reg, devnum_reg, 3'h0};
                `PCCB_OFS_BRIDGE_CTRL: rd_mux = {obusy_s, ibusy_s, 8'h00, ibreset_reg,
                    5'h00};
                `PCCB_OFS_TRANS_CMD: rd_mux = {13'h0000, cmd_reg, 1'b0};
                default: rd_mux = 16'h0000;
            endcase
        end
    endfunction
    always @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            pclk_d_reg <= 1'b0;
            devnum_reg <= `PCCB_DEVNUM_RESET;
            busnum_reg <= `PCCB_BUSNUM_RESET;
            ibreset_reg <= 1'b0;
            cmd_reg <= 2'b00;
            rst_cnt_reg <= 6'h00;
            cfg_rdata_out <= 16'h0000;
            ib_rdata_out <= 16'h0000;
            pcix_status_out <= 16'h0000;
            ibus_reset_out <= 1'b0;
            sec_cfg_valid_out <= 1'b0;
            sec_cfg_addr_out <= 32'h00000000;
            pri_cfg_fwd_out <= 1'b0;
        end
        else
        begin
            pclk_d_reg <= pclk_s;
            if (cfg_wr_set || ib_wr_set)
            begin
                ibreset_reg <= 1'b1;
                rst_cnt_reg <= `PCCB_RESET_CLOCKS;
            end
            else if (soft_rst)
            begin
                if (pclk_rise)
                    rst_cnt_reg <= rst_cnt_reg - 6'h01;
                if (rst_cnt_reg == 6'h01 && pclk_rise)
                    ibreset_reg <= 1'b0;
            end
            if (soft_rst)
            begin
                devnum_reg <= `PCCB_DEVNUM_RESET;
                busnum_reg <= `PCCB_BUSNUM_RESET;
                cmd_reg <= 2'b00;
            end
            else
            begin
                if (cfg_wr_in)
                begin
                    devnum_reg <= mode_s ? ad_in[15:11] : `PCCB_DEVNUM_PCI;
                    if (mode_s && attr_phase_in)
                        busnum_reg <= ad_in[15:8];
                end
                if (cfg_wr_in && cfg_addr_in == `PCCB_OFS_TRANS_CMD)
                    cmd_reg <= cfg_wdata_in[2:1];
                else if (ib_wr_in && ib_addr_in == `PCCB_OFS_TRANS_CMD)
                    cmd_reg <= ib_wdata_in[2:1];
            end
            cfg_rdata_out <= cfg_rd_in ? rd_mux(cfg_addr_in) : 16'h0000;
            ib_rdata_out <= rd_mux(ib_addr_in);
            pcix_status_out <= mode_s ? {busnum_reg, devnum_reg, 3'h0} : 16'h0000;
            ibus_reset_out <= ibreset_reg;
            sec_cfg_valid_out <= sec_cfg_req_in & ~soft_rst;
            sec_cfg_addr_out <= {8'h00, 8'h00, sec_dev_in, 3'h0, sec_reg_in};
            pri_cfg_fwd_out <= 1'b0;
        end
    end
endmodule

// ### testbench/pccb_assertions.sv
`timescale 1ns/1ps
module pccb_chk (
    input wire clk_in, arst_n_in, pcix_mode_in, cfg_wr_in, attr_phase_in, sec_cfg_req_in,
    input wire [7:0] cfg_addr_in,
    input wire [31:0] ad_in,
    input wire [15:0] cfg_wdata_in, pcix_status_out,
    input wire ibus_reset_out, sec_cfg_valid_out, pri_cfg_fwd_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);
    sequence s_rst_wr;
        cfg_wr_in && cfg_addr_in == 8'h84 && cfg_wdata_in[5];
    endsequence
    sequence s_x_wr;
        pcix_mode_in [*4] ##0 cfg_wr_in && !ibus_reset_out;
    endsequence
    a_no_fwd: assert property (!pri_cfg_fwd_out) else $error("fwd");
    a_sec_cycle: assert property (sec_cfg_req_in && !ibus_reset_out |=> sec_cfg_valid_out)
        else $error("sec");
    a_rst_start: assert property (s_rst_wr ##0 !ibus_reset_out |-> ##2 ibus_reset_out)
        else $error("rst");
    a_rst_hold: assert property ($rose(ibus_reset_out) |=> ibus_reset_out [*8])
        else $error("hold");
    a_rst_clear: assert property ($rose(ibus_reset_out) && pcix_mode_in |-> ##4
        pcix_status_out[15:3] == 13'h1FFF) else $error("clr");
    a_pci_zero: assert property (!pcix_mode_in [*6] |-> pcix_status_out == 16'h0000)
        else $error("pci");
    a_dev_num: assert property (s_x_wr |-> ##2 pcix_status_out[7:3] == $past(ad_in[15:11], 2))
        else $error("dev");
    a_bus_num: assert property (s_x_wr ##0 attr_phase_in |-> ##2
        pcix_status_out[15:8] == $past(ad_in[15:8], 2)) else $error("bus");
endmodule
bind pccb_top pccb_chk u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .pcix_mode_in(pcix_mode_in),
    .cfg_wr_in(cfg_wr_in), .attr_phase_in(attr_phase_in), .sec_cfg_req_in(sec_cfg_req_in),
    .cfg_addr_in(cfg_addr_in), .ad_in(ad_in), .cfg_wdata_in(cfg_wdata_in),
    .pcix_status_out(pcix_status_out), .ibus_reset_out(ibus_reset_out),
    .sec_cfg_valid_out(sec_cfg_valid_out), .pri_cfg_fwd_out(pri_cfg_fwd_out));

// ### testbench/pccb_host.sv
`timescale 1ns/1ps
module pccb_host (
    input wire clk_in,
    output logic pclk_out,
    output logic wr_out,
    output logic rd_out,
    output logic at_out,
    output logic [7:0] a_out,
    output logic [31:0] ad_out
);
    initial {pclk_out, wr_out, rd_out, at_out, a_out, ad_out} = 44'h0;
    always #160 pclk_out = ~pclk_out;
    // one config access, strobe seen at one edge; bus inverted once released
    task op(input logic r, input logic t, input logic [7:0] o, input logic [31:0] d);
        @(negedge clk_in);
        {wr_out, rd_out, at_out, a_out, ad_out} = {!r, r, t, o, d};
        @(negedge clk_in);
        {wr_out, rd_out, at_out} = 3'h0;
        ad_out = ~ad_out;
    endtask
endmodule

// ### testbench/pccb_top_tb.sv
`timescale 1ns/1ps
module pccb_top_tb;
    logic clk_in = 0, rst_n = 0, md = 1, ibw = 0, ob = 0, ib = 0, sq = 0;
    wire pc, wr, rd, at, ir, sv, pf;
    wire [7:0] a;
    wire [31:0] ad, sa;
    wire [15:0] cr, ir_d, st;
    int n_errors = 0, cmp_count = 0;
    always #20 clk_in = ~clk_in;
    pccb_host host (.clk_in(clk_in), .pclk_out(pc), .wr_out(wr), .rd_out(rd), .at_out(at),
        .a_out(a), .ad_out(ad));
    pccb_top dut (.clk_in(clk_in), .arst_n_in(rst_n), .pci_clk_in(pc), .pcix_mode_in(md),
        .cfg_wr_in(wr), .cfg_rd_in(rd), .attr_phase_in(at), .cfg_addr_in(a), .ad_in(ad),
        .cfg_wdata_in(ad[15:0]), .ib_wr_in(ibw), .ib_addr_in(8'h84), .ib_wdata_in(16'h0020),
        .ob_busy_in(ob), .ib_busy_in(ib), .sec_cfg_req_in(sq), .sec_dev_in(5'h03),
        .sec_reg_in(8'h10), .cfg_rdata_out(cr), .ib_rdata_out(ir_d), .pcix_status_out(st),
        .ibus_reset_out(ir), .sec_cfg_valid_out(sv), .sec_cfg_addr_out(sa), .pri_cfg_fwd_out(pf));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task wrap_up;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task w(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    initial
    begin
        #60000 n_errors++;
        wrap_up;
    end
    initial
    begin
        w(2);
        rst_n = 1;
        w(4);
        host.op(0, 1, 8'hE4, 32'h5200);
        w(2);
        chk("status", {8'h52, 5'h0A}, st[15:3]);
        host.op(0, 0, 8'hE4, 32'h9B00);
        w(2);
        chk("status", {8'h52, 5'h13}, st[15:3]);
        sq = 1;
        w(1);
        sq = 0;
        chk("sec", {1'b1, 32'h1810}, {sv, sa});
        chk("fwd", 0, pf);
        host.op(0, 0, 8'h04, 32'h0);
        {ob, ib} = 2'b11;
        w(3);
        host.op(1, 0, 8'h84, 32'h0);
        chk("busy", 2'b11, cr[15:14]);
        {ob, ib} = 2'b00;
        w(3);
        host.op(1, 0, 8'h84, 32'h0);
        chk("busy", 0, cr[15:14]);
        host.op(0, 0, 8'h84, 32'h20);
        w(1);
        chk("rst", 2'b11, {ir, ir_d[5]});
        w(340);
        chk("rst", {1'b0, 13'h1FFF}, {ir, st[15:3]});
        ibw = 1;
        w(1);
        ibw = 0;
        w(1);
        chk("rst", 1, ir);
        w(340);
        md = 0;
        w(6);
        host.op(0, 0, 8'hE4, 32'hF800);
        w(2);
        chk("status", 0, st);
        wrap_up;
    end
endmodule
